// >>> rtl/reload_timer.sv
// Purpose: 8-bit up timer/event counter with reload straight from the written reload register and buzzer
// Assumes: ref_clk is the CPU clock; pin inputs synchronous except event
// Notes:   Registers reached over a plain byte port
`timescale 1ns/1ps
`include "reload_timer_regs.svh"
module reload_timer
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire reload_timer_pkg::byte_t reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output reload_timer_pkg::byte_t      reg_rdata,
    // External event pin
    input  wire logic                    external_event_input,
    // Shared buzzer pin and port logic
    input  wire logic                    port_io_out,
    input  wire logic                    port_io_oe,
    output logic                         buzzer_port_pin_out,
    output logic                         buzzer_port_pin_oe,
    // Interrupt side
    output logic                         timer_irq_pulse,
    output logic                         event_pin_irq_mask
);
    import reload_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge detector
    logic ext_fall;

    event_edge_detect edge_u
    (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .event_in   (external_event_input),
        .fall_pulse (ext_fall)
    );

    ////////////////////////////////////////////////////////////////////
    // State
    byte_t mode_reg;
    byte_t mode_next;
    byte_t count_reg;
    byte_t count_next;
    byte_t stage_reg;
    byte_t stage_next;
    byte_t active_reg;
    byte_t active_next;
    byte_t pre_reg;
    byte_t pre_next;
    logic  toggle_reg;
    logic  toggle_next;
    logic  irq_next;
    logic  pin_out_next;
    logic  pin_oe_next;
    logic  mask_next;
    byte_t rdata_next;
    logic  run;
    logic  ext_src;
    rate_t rate;
    logic  tick;
    logic  ovf;
    byte_t pre_mask;

    assign run     = mode_reg[`MODE_RUN_BIT];
    assign ext_src = mode_reg[`MODE_SRC_BIT];
    assign rate    = mode_reg[`MODE_RATE_HI:`MODE_RATE_LO];

    ////////////////////////////////////////////////////////////////////
    // Tick selection and overflow
    always_comb
    begin
        pre_mask = 8'hff >> rate;
        pre_next = pre_reg;
        if (run && !ext_src)
            pre_next = pre_reg + 8'h01;
        if (ext_src)
            tick = run & ext_fall;
        else
            tick = run & ((pre_reg & pre_mask) == pre_mask);
        ovf = tick && (count_reg == 8'hff);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_reg <= `PRESCALE_RESET;
        else
            pre_reg <= pre_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Counter, reload buffers, buzzer, register writes
    always_comb
    begin
        mode_next   = mode_reg;
        count_next  = count_reg;
        stage_next  = stage_reg;
        active_next = active_reg;
        toggle_next = toggle_reg;
        if (tick)
            count_next = count_reg + 8'h01;
        if (ovf)
        begin
            active_next = stage_reg;
            toggle_next = ~toggle_reg;
            if (mode_reg[`MODE_RELOAD_BIT])
                count_next = stage_reg;
            else
                count_next = 8'h00;
        end
        if (reg_wr && reg_addr == `MODE_OFFSET)
            mode_next = reg_wdata & `MODE_WRITE_MASK;
        else if (reg_wr && reg_addr == `COUNT_OFFSET)
            count_next = reg_wdata;
        else if (reg_wr && reg_addr == `RELOAD_OFFSET)
            stage_next = reg_wdata;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg   <= `REG_RESET;
            count_reg  <= `REG_RESET;
            stage_reg  <= `REG_RESET;
            active_reg <= `REG_RESET;
            toggle_reg <= 1'b0;
        end
        else
        begin
            mode_reg   <= mode_next;
            count_reg  <= count_next;
            stage_reg  <= stage_next;
            active_reg <= active_next;
            toggle_reg <= toggle_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs and read data
    always_comb
    begin
        irq_next     = ovf;
        mask_next    = mode_next[`MODE_SRC_BIT];
        pin_oe_next  = port_io_oe;
        pin_out_next = port_io_out;
        if (mode_next[`MODE_OUT_BIT])
        begin
            pin_oe_next  = 1'b1;
            pin_out_next = toggle_next;
        end
        rdata_next = 8'h00;
        if (reg_rd && reg_addr == `MODE_OFFSET)
            rdata_next = mode_reg;
        else if (reg_rd && reg_addr == `COUNT_OFFSET)
            rdata_next = count_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_irq_pulse     <= 1'b0;
            event_pin_irq_mask  <= 1'b0;
            buzzer_port_pin_out <= 1'b0;
            buzzer_port_pin_oe  <= 1'b0;
            reg_rdata           <= `REG_RESET;
        end
        else
        begin
            timer_irq_pulse     <= irq_next;
            event_pin_irq_mask  <= mask_next;
            buzzer_port_pin_out <= pin_out_next;
            buzzer_port_pin_oe  <= pin_oe_next;
            reg_rdata           <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence wrap_s;
        tick && count_reg == 8'hff;
    endsequence

    sequence fast_tick_s;
        run && !ext_src && rate == 3'h7 && tick && !reg_wr;
    endsequence

    sequence fast_gap_s;
        !tick ##1 tick;
    endsequence

    overflow_irq_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wrap_s |=> timer_irq_pulse)
        else $error("overflow without request");
    irq_once_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (timer_irq_pulse && !$past(reg_wr)) |=> !timer_irq_pulse)
        else $error("request longer than one cycle");
    stop_holds_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!run && !reg_wr) |=> $stable(count_reg) && $stable(pre_reg)
            && $stable(toggle_reg))
        else $error("stopped timer changed state");
    stop_noirq_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !run |=> !timer_irq_pulse)
        else $error("request while stopped");
    count_step_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (tick && count_reg != 8'hff && !reg_wr)
            |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not step by one");
    count_write_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `COUNT_OFFSET)
            |=> count_reg == $past(reg_wdata))
        else $error("count write lost");
    read_count_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `COUNT_OFFSET)
            |=> reg_rdata == $past(count_reg))
        else $error("count read back wrong");
    reload_read_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `RELOAD_OFFSET) |=> reg_rdata == 8'h00)
        else $error("reload register not write-only");
    fast_rate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        fast_tick_s ##1 !reg_wr |-> fast_gap_s)
        else $error("divide by two tick spacing wrong");
    slow_rate_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!ext_src && rate == 3'h0 && pre_reg != 8'hff) |-> !tick)
        else $error("divide by 256 ticked early");
    reload_load_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wrap_s and mode_reg[`MODE_RELOAD_BIT] && !reg_wr)
            |=> count_reg == $past(stage_reg))
        else $error("reload value not loaded");
    plain_wrap_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wrap_s and !mode_reg[`MODE_RELOAD_BIT] && !reg_wr)
            |=> count_reg == 8'h00)
        else $error("counter did not wrap to zero");
    stage_write_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `RELOAD_OFFSET)
            |=> stage_reg == $past(reg_wdata))
        else $error("reload write not staged");
    stage_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !ovf |=> $stable(active_reg))
        else $error("active reload changed off overflow");
    buzzer_toggle_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ovf |=> toggle_reg != $past(toggle_reg))
        else $error("buzzer did not toggle");
    ext_count_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ext_src && run && !ext_fall) |-> !tick)
        else $error("external count without edge");
    ext_tick_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ext_src && run && ext_fall) |-> tick)
        else $error("event edge not counted");
    ext_prescale_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ext_src |=> $stable(pre_reg))
        else $error("prescaler moved in event mode");
    pin_drive_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        mode_reg[`MODE_OUT_BIT] |-> buzzer_port_pin_oe
            && buzzer_port_pin_out == toggle_reg)
        else $error("buzzer not driven on pin");
    pin_release_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!mode_reg[`MODE_OUT_BIT] && $past(rst_n))
            |-> buzzer_port_pin_oe == $past(port_io_oe)
            && buzzer_port_pin_out == $past(port_io_out))
        else $error("port drive not passed to pin");
    pin_mask_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        event_pin_irq_mask == ext_src)
        else $error("pin interrupt mask wrong");
endmodule // reload_timer

// >>> rtl/reload_timer_regs.svh
// Purpose: Register offsets, field positions, reset values for reload timer
// Assumes: Byte-wide registers on a plain address port
// Notes:   Definitions only
`ifndef RELOAD_TIMER_REGS_SVH
`define RELOAD_TIMER_REGS_SVH

`define RELOAD_OFFSET      8'hcd
`define MODE_OFFSET        8'hda
`define COUNT_OFFSET       8'hdb
`define MODE_RUN_BIT       7
`define MODE_RATE_HI       6
`define MODE_RATE_LO       4
`define MODE_SRC_BIT       3
`define MODE_RELOAD_BIT    2
`define MODE_OUT_BIT       1
`define MODE_WRITE_MASK    8'hfe
`define REG_RESET          8'h00
`define PRESCALE_RESET     8'h00

`endif

// >>> rtl/reload_timer_pkg.sv
// Purpose: Types shared by the reload timer files
// Assumes: Nothing
// Notes:   Types only
package reload_timer_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] rate_t;
endpackage

// >>> rtl/event_edge_detect.sv
// Purpose: Synchronise the external event pin and flag falling edges
// Assumes: Asynchronous pin, single clock domain
// Notes:   First stage read only by the second stage
`timescale 1ns/1ps
module event_edge_detect
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Pin and edge pulse
    input  wire logic event_in,
    output logic      fall_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic fall_next;

    ////////////////////////////////////////////////////////////////////
    // Two-stage sync, then edge compare on the second stage
    always_comb
    begin
        fall_next = last_reg & ~sync_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg   <= 1'b1;
            sync_reg   <= 1'b1;
            last_reg   <= 1'b1;
            fall_pulse <= 1'b0;
        end
        else
        begin
            meta_reg   <= event_in;
            sync_reg   <= meta_reg;
            last_reg   <= sync_reg;
            fall_pulse <= fall_next;
        end
    end

    single_edge_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        fall_pulse |=> !fall_pulse)
        else $error("edge pulse longer than one cycle");
endmodule // event_edge_detect

// >>> bench/pin_partner.sv
// Purpose: Far-side model of the event pin and the buzzer pin
// Assumes: Event pin idles high between events
// Notes:   Edges are made on request; toggles counted while driven
`timescale 1ns/1ps
module pin_partner
(
    // Clock
    input  wire logic ref_clk,
    // Pins
    output logic      event_pin,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // Toggles seen on the driven pin
    output int        toggles
);
    logic last_pin;
    initial
    begin
        event_pin = 1'b1;
        toggles   = 0;
        last_pin  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Falling edges, four cycles low and five high between edges
    task automatic send_edges(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            event_pin <= 1'b0;
            repeat (4) @(posedge ref_clk);
            event_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    // Count level changes only while the pin is driven
    always @(posedge ref_clk)
    begin
        if (pin_oe === 1'b1 && pin_out !== last_pin)
            toggles <= toggles + 1;
        last_pin <= pin_out;
    end
endmodule // pin_partner

// >>> bench/tb.sv
// Purpose: Self-checking bench for the reload timer
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Expected values worked out from the register map
`timescale 1ns/1ps
`include "reload_timer_regs.svh"
module tb;
    import reload_timer_pkg::*;
    logic       ref_clk     = 1'b0;
    logic       reset_n     = 1'b0;
    logic [7:0] reg_addr    = 8'h00;
    byte_t      reg_wdata   = 8'h00;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic       port_io_out = 1'b0;
    logic       port_io_oe  = 1'b0;
    byte_t      reg_rdata;
    logic       pin_out;
    logic       pin_oe;
    logic       irq;
    logic       mask;
    logic       event_pin;
    logic       p0;
    byte_t      v;
    byte_t      c0;
    int         toggles;
    int         error_cnt   = 0;
    int         checks      = 0;
    int         cyc         = 0;
    int         irq_cnt     = 0;
    int         last_irq    = 0;
    int         gap         = 0;
    int         t0;
    int         i0;

    always #12.5 ref_clk = ~ref_clk;

    reload_timer DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_event_input(event_pin), .port_io_out(port_io_out),
        .port_io_oe(port_io_oe), .buzzer_port_pin_out(pin_out),
        .buzzer_port_pin_oe(pin_oe), .timer_irq_pulse(irq),
        .event_pin_irq_mask(mask));
    pin_partner partner (.ref_clk(ref_clk), .event_pin(event_pin),
        .pin_out(pin_out), .pin_oe(pin_oe), .toggles(toggles));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic conclude();
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Register port cycles
    task automatic wr(input logic [7:0] a, input byte_t d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output byte_t d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_irqs(input int n);
        int target;
        target = irq_cnt + n;
        for (int k = 0; k < 3000 && irq_cnt < target; k++)
            @(posedge ref_clk);
        chk(16'(irq_cnt >= target), 16'd1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Overflow spacing and run-time ceiling
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (irq === 1'b1)
        begin
            irq_cnt  <= irq_cnt + 1;
            gap      <= cyc - last_irq;
            last_irq <= cyc;
        end
        if (cyc > 40000)
        begin
            error_cnt = error_cnt + 1;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(`MODE_OFFSET, v); chk(v, `REG_RESET);
        rd(`COUNT_OFFSET, v); chk(v, `REG_RESET);
        rd(`RELOAD_OFFSET, v); chk(v, 8'h00);
        rd(8'h00, v); chk(v, 8'h00);
        wr(`COUNT_OFFSET, 8'ha5);
        rd(`COUNT_OFFSET, v); chk(v, 8'ha5);
        wr(`RELOAD_OFFSET, 8'h3c);
        rd(`RELOAD_OFFSET, v); chk(v, 8'h00);
        rd(`COUNT_OFFSET, v); chk(v, 8'ha5);
        wr(`MODE_OFFSET, 8'h01);
        rd(`MODE_OFFSET, v); chk(v, 8'h00);
        // Ordinary port drive passes while the output bit is clear
        @(posedge ref_clk);
        port_io_out <= 1'b1;
        port_io_oe  <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({pin_oe, pin_out}, 2'b11);
        port_io_out <= 1'b0;
        port_io_oe  <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({pin_oe, pin_out}, 2'b00);
        // Every rate, two ticks per overflow with auto-reload
        for (int r = 0; r < 8; r++)
        begin
            wr(`MODE_OFFSET, 8'h00);
            wr(`RELOAD_OFFSET, 8'hfe);
            wr(`COUNT_OFFSET, 8'hfe);
            wr(`MODE_OFFSET, 8'(8'h84 | (r << 4)));
            wait_irqs(2);
            chk(16'(gap), 16'(2 * (256 >> r)));
        end
        // Buzzer toggles once per overflow
        wr(`MODE_OFFSET, 8'hb6);
        wait_irqs(1);
        repeat (4) @(posedge ref_clk);
        t0 = toggles;
        i0 = irq_cnt;
        wait_irqs(4);
        repeat (4) @(posedge ref_clk);
        chk(16'(toggles - t0), 16'd4);
        chk(16'(irq_cnt - i0), 16'd4);
        chk(pin_oe, 1'b1);
        // Stopped timer holds everything
        wr(`MODE_OFFSET, 8'h36);
        rd(`COUNT_OFFSET, c0);
        p0 = pin_out;
        i0 = irq_cnt;
        repeat (300) @(posedge ref_clk);
        rd(`COUNT_OFFSET, v); chk(v, c0);
        chk(16'(pin_out), 16'(p0));
        chk(16'(irq_cnt - i0), 16'd0);
        // Plain wrap without reload restarts from zero
        wr(`MODE_OFFSET, 8'h00);
        wr(`COUNT_OFFSET, 8'hfd);
        wr(`MODE_OFFSET, 8'hf0);
        wait_irqs(1);
        rd(`COUNT_OFFSET, v); chk(16'(v < 8'h04), 16'd1);
        // External events, rate bits set but ignored
        wr(`MODE_OFFSET, 8'h00);
        wr(`COUNT_OFFSET, 8'hfd);
        wr(`MODE_OFFSET, 8'hf8);
        i0 = irq_cnt;
        partner.send_edges(5);
        repeat (6) @(posedge ref_clk);
        rd(`COUNT_OFFSET, v); chk(v, 8'h02);
        chk(16'(irq_cnt - i0), 16'd1);
        chk(mask, 1'b1);
        wr(`MODE_OFFSET, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(mask, 1'b0);
        conclude();
    end
endmodule // tb
